// *** gpio_sink_model.sv ***
// Model of the equipment on the trigger output pin
`timescale 1ns/10ps

module gpio_sink_model
(
	input  wire logic        clock_i,
	input  wire logic        clear_i,
	input  wire logic        level_i,
	output logic      [15:0] rises_o,
	output logic      [15:0] high_o,
	output logic      [15:0] run_o
);
	logic prev_r;
	always_ff @(posedge clock_i)
	begin
		prev_r <= level_i;
		if (clear_i)
		begin
			rises_o <= 16'h0000;
			high_o <= 16'h0000;
			run_o <= 16'h0000;
		end
		else if (level_i)
		begin
			rises_o <= rises_o + 16'(!prev_r);
			high_o <= high_o + 16'h0001;
			run_o <= (prev_r ? run_o : 16'h0000) + 16'h0001;
		end
	end
endmodule

// *** ns_phase_timer.sv ***
// Nanosecond phase accumulator with wrap at a programmable interval
`timescale 1ns/10ps
`include "trig_wave_cfg.svh"

module ns_phase_timer
(
	input  wire logic        clock_i,
	input  wire logic        nrst_i,
	input  wire logic        run_i,
	input  wire logic [31:0] period_ns_i,
	output logic      [31:0] phase_ns_o,
	output logic             wrap_o
);

	logic [31:0] phase_r;
	logic [31:0] phase_nxt;
	logic [32:0] sum;
	logic [32:0] period_ext;
	logic        short_period;

	// ------------------------------------------------------------------------
	// Advance by one clock period in ns, fold back at interval end
	// ------------------------------------------------------------------------
	assign sum          = {1'b0, phase_r} + 33'(`STEP_NS);
	assign period_ext   = {1'b0, period_ns_i};
	assign short_period = period_ext <= 33'(`STEP_NS);
	assign wrap_o       = run_i & (sum >= period_ext);
	assign phase_nxt    = !run_i ? 32'h0000_0000 :
	                      !wrap_o ? sum[31:0] :
	                      short_period ? 32'h0000_0000 : 32'(sum - period_ext);
	assign phase_ns_o   = phase_nxt;

	always_ff @(posedge clock_i)
	begin
		if (!nrst_i)
			phase_r <= 32'h0000_0000;
		else
			phase_r <= phase_nxt;
	end

endmodule

// *** trig_wave_cfg.svh ***
// Constants for the trigger waveform timing block
`ifndef TRIG_WAVE_CFG_SVH
`define TRIG_WAVE_CFG_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define ADDR_PULSE_WIDTH   12'h22a
`define ADDR_PERIOD_LOW    12'h22c
`define ADDR_PERIOD_HIGH   12'h22e
`define ADDR_CYCLE_COUNT   12'h230
`define ADDR_PATTERN       12'h232
`define ADDR_CONTROL       12'h238
`define ADDR_STATUS        12'h23a

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define RST_REG16          16'h0000
`define RST_CONTROL        8'h00
`define RST_OUT            1'b1

// ----------------------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------------------
`define CTRL_MODE_HI       2
`define CTRL_MODE_LO       0
`define CTRL_ENABLE        3
`define CTRL_CASCADE       4
`define CTRL_TAIL_SET      5
`define CTRL_TAIL_SELF     6
`define CTRL_WIDTH         8

// ----------------------------------------------------------------------------
// Status fields
// ----------------------------------------------------------------------------
`define STAT_BUSY          0
`define STAT_DONE          1
`define STAT_LEVEL         2
`define STAT_WAIT          3

// ----------------------------------------------------------------------------
// Waveform codes
// ----------------------------------------------------------------------------
`define MODE_NEG_EDGE      3'h0
`define MODE_POS_EDGE      3'h1
`define MODE_NEG_PULSE     3'h2
`define MODE_POS_PULSE     3'h3
`define MODE_NEG_CYCLE     3'h4
`define MODE_POS_CYCLE     3'h5
`define MODE_PATTERN       3'h6

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define CLK_PERIOD_NS      25
`define PULSE_UNIT_NS      8
`define PULSE_UNIT_SHIFT   3
`define STEP_NS            (`CLK_PERIOD_NS)

`endif

// *** trig_wave_pkg.sv ***
// Types shared by the trigger waveform timing block
package trig_wave_pkg;

	typedef enum logic [1:0]
	{
		ST_IDLE,
		ST_RUN,
		ST_WAIT,
		ST_DONE
	} trig_state_t;

endpackage

// *** trig_wave_sva.sv ***
// Checker for the trigger waveform timing block
`timescale 1ns/10ps
`include "trig_wave_cfg.svh"

module trig_wave_sva
(
	input  wire logic        clock_i,
	input  wire logic        nrst_i,
	input  wire logic [11:0] addr_i,
	input  wire logic [15:0] wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	input  wire logic [15:0] rdata_o,
	input  wire logic        target_hit_i,
	input  wire logic        trig_out_o,
	input  wire logic        busy_o
);
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!nrst_i);
	logic [15:0] shd_r [0:4];
	logic [15:0] rdx_r;
	logic [7:0]  ctl_r;
	logic        arm_r;
	wire  [11:0] ofs    = addr_i - `ADDR_PULSE_WIDTH;
	wire         map    = (ofs < 12'h00a) && !ofs[0];
	wire  [2:0]  idx    = ofs[3:1];
	wire         ctl_wr = wr_i && (addr_i == `ADDR_CONTROL);
	always_ff @(posedge clock_i)
	begin
		rdx_r <= shd_r[idx];
		if (!nrst_i)
		begin
			shd_r <= '{default: 16'h0000};
			ctl_r <= 8'h00;
			arm_r <= 1'b0;
		end
		else
		begin
			if (wr_i && map)
				shd_r[idx] <= wdata_i;
			if (ctl_wr)
				ctl_r <= wdata_i[7:0];
			arm_r <= (ctl_wr && wdata_i[3] && !ctl_r[3]) || (arm_r && !target_hit_i && !ctl_wr);
		end
	end
	// ------------------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------------------
	sequence hi_four;
		trig_out_o [*4] ##1 !trig_out_o;
	endsequence
	chk_rd_idle: assert property (!$past(rd_i) |-> rdata_o == 16'h0000)
		else $error("read data not zero outside read cycle");
	chk_rd_shadow: assert property (rd_i && map |=> rdata_o == rdx_r)
		else $error("register read back differs from last write");
	chk_pulse_width: assert property ($rose(trig_out_o)
		&& ctl_r[2:0] == `MODE_POS_PULSE && shd_r[0] == 16'h000a |-> hi_four)
		else $error("positive pulse width wrong");
	chk_busy_start: assert property (arm_r && target_hit_i
		&& ctl_r[2:1] != 2'b00 && ctl_r[2:0] != 3'h7 |=> busy_o)
		else $error("waveform did not start on target hit");
	chk_edge_level: assert property (arm_r && target_hit_i
		&& ctl_r[2:1] == 2'b00 |-> ##[1:2] (trig_out_o == ctl_r[0] && !busy_o))
		else $error("edge mode level wrong");
	chk_idle_quiet: assert property (!busy_o && !target_hit_i |=> !busy_o)
		else $error("busy without target hit");
	chk_out_hold: assert property (!busy_o && !wr_i && !$past(wr_i)
		&& !target_hit_i && !$past(target_hit_i) |=> $stable(trig_out_o))
		else $error("output moved while idle");
	chk_reset_out: assert property ($rose(nrst_i) |-> trig_out_o && !busy_o)
		else $error("wrong output after reset");
endmodule

bind trigger_waveform_timing_config trig_wave_sva trig_wave_sva_inst
(
	.clock_i(clock_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
	.rd_i(rd_i), .rdata_o(rdata_o), .target_hit_i(target_hit_i), .trig_out_o(trig_out_o),
	.busy_o(busy_o)
);

// *** trigger_waveform_timing_config.sv ***
// Waveform shaping for one time-triggered output unit
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/10ps
`include "trig_wave_cfg.svh"

module trigger_waveform_timing_config
	import trig_wave_pkg::*;
(
	input  wire logic        clock_i,
	input  wire logic        nrst_i,
	input  wire logic [11:0] addr_i,
	input  wire logic [15:0] wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	output logic      [15:0] rdata_o,
	input  wire logic        target_hit_i,
	output logic             trig_out_o,
	output logic             busy_o
);

	// ------------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------------
	logic [15:0]            pulse_width_or_tail_iterations_r;
	logic [15:0]            period_width_low_r;
	logic [15:0]            period_width_high_r;
	logic [15:0]            cycle_or_bit_count_r;
	logic [15:0]            pattern_or_iterations_r;
	logic [`CTRL_WIDTH-1:0] control_r;

	trig_state_t            state_r;
	trig_state_t            state_nxt;
	logic [15:0]            unit_cnt_r;
	logic [15:0]            unit_cnt_nxt;
	logic [3:0]             bit_idx_r;
	logic [3:0]             bit_idx_nxt;
	logic [15:0]            iter_cnt_r;
	logic [15:0]            iter_cnt_nxt;
	logic                   out_r;
	logic                   out_nxt;
	logic                   busy_r;
	logic                   busy_nxt;

	// ------------------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------------------
	wire sel_pulse   = addr_i == `ADDR_PULSE_WIDTH;
	wire sel_per_lo  = addr_i == `ADDR_PERIOD_LOW;
	wire sel_per_hi  = addr_i == `ADDR_PERIOD_HIGH;
	wire sel_count   = addr_i == `ADDR_CYCLE_COUNT;
	wire sel_pattern = addr_i == `ADDR_PATTERN;
	wire sel_control = addr_i == `ADDR_CONTROL;
	wire sel_status  = addr_i == `ADDR_STATUS;

	// ------------------------------------------------------------------------
	// Control fields
	// ------------------------------------------------------------------------
	wire [2:0] mode       = control_r[`CTRL_MODE_HI:`CTRL_MODE_LO];
	wire       enable     = control_r[`CTRL_ENABLE];
	wire       cascade    = control_r[`CTRL_CASCADE];
	wire       tail_set   = control_r[`CTRL_TAIL_SET];
	wire       tail_self  = control_r[`CTRL_TAIL_SELF];

	wire is_edge    = (mode == `MODE_NEG_EDGE) | (mode == `MODE_POS_EDGE);
	wire is_pulse   = (mode == `MODE_NEG_PULSE) | (mode == `MODE_POS_PULSE);
	wire is_cycle   = (mode == `MODE_NEG_CYCLE) | (mode == `MODE_POS_CYCLE);
	wire is_pattern = mode == `MODE_PATTERN;
	wire is_wave    = is_pulse | is_cycle | is_pattern;

	// ------------------------------------------------------------------------
	// Levels: odd codes high-active, even codes low-active except pattern code 6, which idles low
	// ------------------------------------------------------------------------
	wire active_lvl = mode[0];
	wire idle_lvl   = is_pattern ? 1'b0 : ~mode[0];

	// ------------------------------------------------------------------------
	// State decode
	// ------------------------------------------------------------------------
	wire in_run  = state_r == ST_RUN;
	wire in_wait = state_r == ST_WAIT;
	wire in_done = state_r == ST_DONE;

	// ------------------------------------------------------------------------
	// Timing values
	// ------------------------------------------------------------------------
	wire [31:0] pulse_ns  = 32'(pulse_width_or_tail_iterations_r) << `PULSE_UNIT_SHIFT;
	wire [31:0] period_ns = {period_width_high_r, period_width_low_r};
	wire [31:0] timer_period = is_pulse ? pulse_ns : period_ns;

	// Phase in the coming cycle
	logic [31:0] phase_ns;
	logic        wrap;

	ns_phase_timer u_timer
	(
		.clock_i     (clock_i),
		.nrst_i      (nrst_i),
		.run_i       (in_run),
		.period_ns_i (timer_period),
		.phase_ns_o  (phase_ns),
		.wrap_o      (wrap)
	);

	// ------------------------------------------------------------------------
	// Group and iteration bookkeeping
	// ------------------------------------------------------------------------
	wire count_bounded = cycle_or_bit_count_r != `RST_REG16;
	wire unit_last     = unit_cnt_r == 16'(cycle_or_bit_count_r - 16'h0001);
	wire unit_end      = wrap & count_bounded & unit_last;
	wire group_end     = is_pulse ? wrap : unit_end;

	// ------------------------------------------------------------------------
	// Tail repeats: pulse-width register in pattern mode, pattern register otherwise
	// ------------------------------------------------------------------------
	wire [15:0] iter_limit = is_pattern ? pulse_width_or_tail_iterations_r
	                                    : pattern_or_iterations_r;
	wire iter_counted = cascade & tail_set & tail_self;
	wire iter_last    = iter_cnt_r == iter_limit;

	// ------------------------------------------------------------------------
	// Level in the coming cycle, from the coming phase and bit index
	// ------------------------------------------------------------------------
	wire cycle_lvl   = (phase_ns < pulse_ns) ? active_lvl : ~active_lvl;
	wire pattern_lvl = pattern_or_iterations_r[bit_idx_nxt];
	wire run_lvl     = is_pattern ? pattern_lvl :
	                   is_cycle ? cycle_lvl : active_lvl;

	// ------------------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------------------
	always_comb
	begin
		state_nxt    = state_r;
		unit_cnt_nxt = unit_cnt_r;
		bit_idx_nxt  = bit_idx_r;
		iter_cnt_nxt = iter_cnt_r;
		case (state_r)
			ST_IDLE:
			begin
				unit_cnt_nxt = 16'h0000;
				bit_idx_nxt  = 4'h0;
				iter_cnt_nxt = 16'h0000;
				if (target_hit_i)
					state_nxt = is_wave ? ST_RUN : ST_DONE;
			end
			ST_RUN:
			begin
				if (wrap)
				begin
					unit_cnt_nxt = 16'(unit_cnt_r + 16'h0001);
					bit_idx_nxt  = 4'(bit_idx_r + 4'h1);
				end
				if (group_end)
				begin
					unit_cnt_nxt = 16'h0000;
					bit_idx_nxt  = 4'h0;
					if (!cascade)
						state_nxt = ST_DONE;
					else if (iter_counted && iter_last)
						state_nxt = ST_DONE;
					else
					begin
						state_nxt    = ST_WAIT;
						iter_cnt_nxt = 16'(iter_cnt_r + 16'h0001);
					end
				end
			end
			ST_WAIT:
			begin
				if (target_hit_i)
					state_nxt = ST_RUN;
			end
			ST_DONE:
			begin
				state_nxt = ST_DONE;
			end
			default:
			begin
				state_nxt = ST_IDLE;
			end
		endcase
		if (!enable)
			state_nxt = ST_IDLE;
	end

	// ------------------------------------------------------------------------
	// Output level for the coming cycle
	// ------------------------------------------------------------------------
	always_comb
	begin
		case (state_nxt)
			ST_RUN:  out_nxt = run_lvl;
			ST_WAIT: out_nxt = idle_lvl;
			ST_DONE: out_nxt = is_edge ? active_lvl : idle_lvl;
			default: out_nxt = idle_lvl;
		endcase
	end

	always_ff @(posedge clock_i)
	begin
		if (!nrst_i)
		begin
			state_r    <= ST_IDLE;
			unit_cnt_r <= 16'h0000;
			bit_idx_r  <= 4'h0;
			iter_cnt_r <= 16'h0000;
			out_r      <= `RST_OUT;
			busy_r     <= 1'b0;
		end
		else
		begin
			state_r    <= state_nxt;
			unit_cnt_r <= unit_cnt_nxt;
			bit_idx_r  <= bit_idx_nxt;
			iter_cnt_r <= iter_cnt_nxt;
			out_r      <= out_nxt;
			busy_r     <= busy_nxt;
		end
	end

	// ------------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------------
	assign busy_nxt   = (state_nxt == ST_RUN) | (state_nxt == ST_WAIT);
	assign trig_out_o = out_r;
	assign busy_o     = busy_r;

	// ------------------------------------------------------------------------
	// Register writes
	// ------------------------------------------------------------------------
	always_ff @(posedge clock_i)
	begin
		if (!nrst_i)
		begin
			pulse_width_or_tail_iterations_r <= `RST_REG16;
			period_width_low_r               <= `RST_REG16;
			period_width_high_r              <= `RST_REG16;
			cycle_or_bit_count_r             <= `RST_REG16;
			pattern_or_iterations_r          <= `RST_REG16;
			control_r                        <= `RST_CONTROL;
		end
		else if (wr_i)
		begin
			if (sel_pulse)
				pulse_width_or_tail_iterations_r <= wdata_i;
			if (sel_per_lo)
				period_width_low_r <= wdata_i;
			if (sel_per_hi)
				period_width_high_r <= wdata_i;
			if (sel_count)
				cycle_or_bit_count_r <= wdata_i;
			if (sel_pattern)
				pattern_or_iterations_r <= wdata_i;
			if (sel_control)
				control_r <= wdata_i[`CTRL_WIDTH-1:0];
		end
	end

	// ------------------------------------------------------------------------
	// Register reads
	// ------------------------------------------------------------------------
	logic [15:0] status_word;
	logic [15:0] read_mux;

	always_comb
	begin
		status_word              = 16'h0000;
		status_word[`STAT_BUSY]  = busy_o;
		status_word[`STAT_DONE]  = in_done;
		status_word[`STAT_LEVEL] = out_r;
		status_word[`STAT_WAIT]  = in_wait;
	end

	assign read_mux = sel_pulse   ? pulse_width_or_tail_iterations_r :
	                  sel_per_lo  ? period_width_low_r :
	                  sel_per_hi  ? period_width_high_r :
	                  sel_count   ? cycle_or_bit_count_r :
	                  sel_pattern ? pattern_or_iterations_r :
	                  sel_control ? 16'(control_r) :
	                  sel_status  ? status_word : 16'h0000;

	// Zero outside the read strobe
	wire [15:0] read_word = rd_i ? read_mux : 16'h0000;

	always_ff @(posedge clock_i)
	begin
		if (!nrst_i)
			rdata_o <= 16'h0000;
		else
			rdata_o <= read_word;
	end

endmodule

// *** trigger_waveform_timing_config_tb.sv ***
// Testbench for the trigger waveform timing block
`timescale 1ns/10ps
`include "trig_wave_cfg.svh"

module trigger_waveform_timing_config_tb;
	logic        clock_i = 1'b0;
	logic        nrst_i = 1'b0;
	logic [11:0] addr_i = 12'h000;
	logic [15:0] wdata_i = 16'h0000;
	logic        wr_i = 1'b0;
	logic        rd_i = 1'b0;
	logic        target_hit_i = 1'b0;
	logic        clear = 1'b1;
	logic [15:0] rdata_o;
	logic        trig_out_o;
	logic        busy_o;
	logic [15:0] rises;
	logic [15:0] highs;
	logic [15:0] run;
	int          fails = 0;
	int          n_compared = 0;
	int          cyc = 0;

	trigger_waveform_timing_config trigger_waveform_timing_config_inst
	(
		.clock_i(clock_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
		.rd_i(rd_i), .rdata_o(rdata_o), .target_hit_i(target_hit_i),
		.trig_out_o(trig_out_o), .busy_o(busy_o)
	);
	gpio_sink_model gpio_sink_model_inst
	(
		.clock_i(clock_i), .clear_i(clear), .level_i(trig_out_o), .rises_o(rises),
		.high_o(highs), .run_o(run)
	);
	// ------------------------------------------------------------------------
	// Clock, timeout and bus tasks
	// ------------------------------------------------------------------------
	initial forever #12.5 clock_i = ~clock_i;
	always @(posedge clock_i)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			fails++;
			end_sim;
		end
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			fails++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [15:0] d);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clock_i);
		wr_i <= 1'b0;
		@(posedge clock_i);
	endtask
	task automatic rd(input logic [11:0] a, input logic [15:0] e);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clock_i);
		rd_i <= 1'b0;
		@(negedge clock_i);
		chk(rdata_o, e);
		@(posedge clock_i);
	endtask
	task automatic arm(input logic [7:0] c);
		wr(`ADDR_CONTROL, 16'h0000);
		wr(`ADDR_CONTROL, {8'h00, c});
		clear <= 1'b1;
		@(posedge clock_i);
		clear <= 1'b0;
	endtask
	task automatic hit(input int n);
		repeat (n)
		begin
			target_hit_i <= 1'b1;
			@(posedge clock_i);
			target_hit_i <= 1'b0;
			repeat (10) @(posedge clock_i);
		end
	endtask
	task automatic fin(input logic [15:0] r, input logic [15:0] b);
		@(negedge clock_i);
		for (int i = 0; i < 400 && busy_o !== 1'b0; i++)
			@(negedge clock_i);
		chk(rises, r);
		chk(16'(busy_o), b);
		@(posedge clock_i);
	endtask
	task automatic casc(input logic [7:0] c, input logic [15:0] p, input logic [15:0] r,
		input logic [15:0] b);
		wr(`ADDR_PULSE_WIDTH, p);
		arm(c);
		hit(3);
		fin(r, b);
	endtask
	task automatic end_sim;
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// ------------------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------------------
	initial
	begin
		repeat (20) @(posedge clock_i);
		nrst_i <= 1'b1;
		@(posedge clock_i);
		for (int i = 0; i < 5; i++)
			rd(12'(`ADDR_PULSE_WIDTH + 2 * i), 16'h0000);
		for (int i = 0; i < 5; i++)
		begin
			wr(12'(`ADDR_PULSE_WIDTH + 2 * i), 16'(16'h1234 * (i + 1)));
			rd(12'(`ADDR_PULSE_WIDTH + 2 * i), 16'(16'h1234 * (i + 1)));
		end
		wr(12'h234, 16'hffff);
		rd(12'h234, 16'h0000);
		$display("test registers done");
		wr(`ADDR_PULSE_WIDTH, 16'h000a);
		for (int m = 0; m < 4; m++)
		begin
			arm(8'(8 + m));
			hit(1);
			fin(16'(m > 0), 16'h0000);
			chk(16'(trig_out_o), 16'(m == 1 || m == 2));
		end
		chk(run, 16'h0004);
		rd(`ADDR_CONTROL, 16'h000b);
		rd(`ADDR_STATUS, 16'h0002);
		$display("test single modes done");
		wr(`ADDR_PERIOD_LOW, 16'h0064);
		wr(`ADDR_PERIOD_HIGH, 16'h0000);
		wr(`ADDR_PULSE_WIDTH, 16'h0005);
		wr(`ADDR_CYCLE_COUNT, 16'h0003);
		for (int m = 4; m < 6; m++)
		begin
			arm(8'(8 + m));
			hit(1);
			fin(16'h0003, 16'h0000);
		end
		wr(`ADDR_CYCLE_COUNT, 16'h0000);
		arm(8'h0d);
		hit(1);
		repeat (200) @(negedge clock_i);
		chk(16'(busy_o), 16'h0001);
		chk(16'(rises > 16'h0028), 16'h0001);
		@(posedge clock_i);
		$display("test periodic done");
		wr(`ADDR_PERIOD_LOW, 16'h0019);
		wr(`ADDR_PATTERN, 16'h001d);
		wr(`ADDR_CYCLE_COUNT, 16'h0005);
		arm(8'h0e);
		hit(1);
		fin(16'h0002, 16'h0000);
		chk(run, 16'h0003);
		chk(highs, 16'h0004);
		wr(`ADDR_PATTERN, 16'h0001);
		wr(`ADDR_CYCLE_COUNT, 16'h0011);
		arm(8'h0e);
		hit(1);
		fin(16'h0002, 16'h0000);
		$display("test pattern done");
		wr(`ADDR_PERIOD_LOW, 16'h0064);
		wr(`ADDR_CYCLE_COUNT, 16'h0001);
		casc(8'h7e, 16'h0000, 16'h0001, 16'h0000);
		casc(8'h1e, 16'h0000, 16'h0003, 16'h0001);
		rd(`ADDR_STATUS, 16'h0009);
		casc(8'h7d, 16'h0005, 16'h0002, 16'h0000);
		casc(8'h1d, 16'h0005, 16'h0003, 16'h0001);
		$display("test cascade done");
		end_sim;
	end
endmodule
